// file: hw/tcpu_top.sv
`timescale 1ns/10ps
// Behaviour
// - each unit counts with a 16-bit counter whose period software programs
// - a capture event, always from a pin, stores the counter in capture
// - on period match the counter halts or reloads, chosen by configuration
// - counter compared against programmable compare value sets pwm duty cycle
// - true and complementary outputs separated by a programmable dead band
// - kill input forces outputs to safe state within three clock cycles, no software
// - eight independent units, each with counter, registers and output pair
module tcpu_top
    import tcpu_pkg::*;
#(
    parameter int NUM_UNITS = TCPU_NUM_UNITS
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // register port
    input  wire logic [2:0]           i_unit,
    input  wire logic [7:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    // pins
    input  wire logic [NUM_UNITS-1:0] i_capture,
    input  wire logic [NUM_UNITS-1:0] i_kill,
    output logic      [NUM_UNITS-1:0] o_line,
    output logic      [NUM_UNITS-1:0] o_line_n,
    // interrupt
    output logic                      o_irq
);
    // unit select is three bits wide, so more than eight units cannot be addressed
    if (NUM_UNITS < 1 || NUM_UNITS > 8) begin : g_bad_units
        $error("tcpu_top: NUM_UNITS must be 1..8");
    end

    logic [NUM_UNITS-1:0] cap_s;
    logic [NUM_UNITS-1:0] kill_s;
    logic [NUM_UNITS-1:0] irq_unit;
    logic [31:0]          rd_unit [NUM_UNITS];

    tcpu_sync #(.W(NUM_UNITS)) u_sync_cap (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_capture),
        .o_q     (cap_s)
    );
    tcpu_sync #(.W(NUM_UNITS)) u_sync_kill (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_kill),
        .o_q     (kill_s)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++) begin : g_unit
            logic                          sel;
            logic                          wr;
            logic [TCPU_CTRL_W-1:0]        ctrl_q;
            logic [TCPU_CNT_W-1:0]         period_q;
            logic [TCPU_CNT_W-1:0]         cmp_q;
            logic [TCPU_DEAD_W-1:0]        dead_q;
            logic [TCPU_CNT_W-1:0]         count_q;
            logic [TCPU_CNT_W-1:0]         capture_q;
            logic [TCPU_EV_W-1:0]          status_q;
            logic [TCPU_EV_W-1:0]          mask_q;
            logic                          cap_prev_q;
            logic                          pwm_q;
            logic                          cap_ev;
            logic                          match;
            logic                          cmp_hit;
            logic [TCPU_EV_W-1:0]          ev;
            logic                          line_raw;
            logic                          line_n_raw;
            logic                          run;
            logic [31:0]                   rd_word;

            assign sel   = (i_unit == 3'(g));
            assign wr    = i_wr && sel;
            assign run   = ctrl_q[TCPU_CTRL_RUN];
            assign match = run && (count_q == period_q);
            assign cmp_hit = run && (count_q == cmp_q);
            // capture edge selectable: rising or falling
            assign cap_ev = (cap_s[g] != cap_prev_q) &&
                            (cap_s[g] != ctrl_q[TCPU_CTRL_CAPEDGE]);

            always_comb begin
                ev = '0;
                ev[TCPU_EV_MATCH]   = match;
                ev[TCPU_EV_CMP]     = cmp_hit;
                ev[TCPU_EV_CAPTURE] = cap_ev;
                ev[TCPU_EV_KILL]    = kill_s[g];
            end

            // configuration registers
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    period_q <= TCPU_PERIOD_RST;
                    cmp_q    <= TCPU_CMP_RST;
                    dead_q   <= TCPU_DEAD_RST;
                    mask_q   <= '0;
                end else if (wr) begin
                    case (i_addr)
                        TCPU_OFS_PERIOD: period_q <= i_wdata[TCPU_CNT_W-1:0];
                        TCPU_OFS_CMP:    cmp_q    <= i_wdata[TCPU_CNT_W-1:0];
                        TCPU_OFS_DEAD:   dead_q   <= i_wdata[TCPU_DEAD_W-1:0];
                        TCPU_OFS_MASK:   mask_q   <= i_wdata[TCPU_EV_W-1:0];
                        default: begin
                        end
                    endcase
                end
            end

            // control; the run bit drops by itself in one-shot mode
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_q <= '0;
                end else if (wr && i_addr == TCPU_OFS_CTRL) begin
                    ctrl_q <= i_wdata[TCPU_CTRL_W-1:0];
                end else if (match && ctrl_q[TCPU_CTRL_ONESHOT]) begin
                    ctrl_q[TCPU_CTRL_RUN] <= 1'b0;
                end
            end

            // counter; software write of count wins over counting
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    count_q <= '0;
                end else if (wr && i_addr == TCPU_OFS_COUNT) begin
                    count_q <= i_wdata[TCPU_CNT_W-1:0];
                end else if (match) begin
                    // halt holds the final value, reload starts over
                    if (!ctrl_q[TCPU_CTRL_ONESHOT]) begin
                        count_q <= '0;
                    end
                end else if (run) begin
                    count_q <= count_q + 1'b1;
                end
            end

            // capture
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cap_prev_q <= 1'b0;
                    capture_q  <= '0;
                end else begin
                    cap_prev_q <= cap_s[g];
                    if (cap_ev) begin
                        capture_q <= count_q;
                    end
                end
            end

            // pwm: high while count below compare, optionally inverted
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pwm_q <= 1'b0;
                end else begin
                    pwm_q <= run && ((count_q < cmp_q) ^ ctrl_q[TCPU_CTRL_INVERT]);
                end
            end

            // sticky status; a new event wins over a write-one clear
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    status_q <= '0;
                end else if (wr && i_addr == TCPU_OFS_STATUS) begin
                    status_q <= (status_q & ~i_wdata[TCPU_EV_W-1:0]) | ev;
                end else begin
                    status_q <= status_q | ev;
                end
            end

            // kill path bypasses the counter so the force lands in three cycles
            tcpu_deadband u_db (
                .i_clk      (i_clk),
                .i_rst_n    (i_rst_n),
                .i_pwm      (pwm_q),
                .i_dead     (dead_q),
                .i_kill     (kill_s[g]),
                .i_kill_lvl (ctrl_q[TCPU_CTRL_KILLLVL]),
                .o_line     (line_raw),
                .o_line_n   (line_n_raw)
            );
            assign o_line[g]   = line_raw;
            assign o_line_n[g] = line_n_raw;
            assign irq_unit[g] = |(status_q & mask_q);

            // one local word per unit keeps each array entry to a single driver
            always_comb begin
                rd_word = 32'h0000_0000;
                case (i_addr)
                    TCPU_OFS_CTRL:    rd_word = 32'(ctrl_q);
                    TCPU_OFS_PERIOD:  rd_word = 32'(period_q);
                    TCPU_OFS_CMP:     rd_word = 32'(cmp_q);
                    TCPU_OFS_DEAD:    rd_word = 32'(dead_q);
                    TCPU_OFS_COUNT:   rd_word = 32'(count_q);
                    TCPU_OFS_CAPTURE: rd_word = 32'(capture_q);
                    TCPU_OFS_STATUS:  rd_word = 32'(status_q);
                    TCPU_OFS_MASK:    rd_word = 32'(mask_q);
                    default:          rd_word = 32'h0000_0000;
                endcase
            end
            assign rd_unit[g] = rd_word;
        end
    endgenerate

    // read data: one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd && (32'(i_unit) < NUM_UNITS)) begin
            o_rdata <= rd_unit[i_unit];
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |irq_unit;
        end
    end
endmodule : tcpu_top

// file: hw/tcpu_pkg.sv
package tcpu_pkg;
    // register indices on the plain register port (word per index)
    localparam logic [7:0] TCPU_OFS_CTRL    = 8'h00;
    localparam logic [7:0] TCPU_OFS_PERIOD  = 8'h01;
    localparam logic [7:0] TCPU_OFS_CMP     = 8'h02;
    localparam logic [7:0] TCPU_OFS_DEAD    = 8'h03;
    localparam logic [7:0] TCPU_OFS_COUNT   = 8'h04;
    localparam logic [7:0] TCPU_OFS_CAPTURE = 8'h05;
    localparam logic [7:0] TCPU_OFS_STATUS  = 8'h06;
    localparam logic [7:0] TCPU_OFS_MASK    = 8'h07;
    // control field positions
    localparam int TCPU_CTRL_RUN     = 0;
    localparam int TCPU_CTRL_ONESHOT = 1;
    localparam int TCPU_CTRL_CAPEDGE = 2;
    localparam int TCPU_CTRL_KILLLVL = 3;
    localparam int TCPU_CTRL_INVERT  = 4;
    localparam int TCPU_CTRL_W       = 5;
    // status / mask bit positions
    localparam int TCPU_EV_MATCH   = 0;
    localparam int TCPU_EV_CMP     = 1;
    localparam int TCPU_EV_CAPTURE = 2;
    localparam int TCPU_EV_KILL    = 3;
    localparam int TCPU_EV_W       = 4;
    // values after reset, then widths and counts
    localparam logic [15:0] TCPU_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] TCPU_CMP_RST    = 16'h8000;
    localparam logic [7:0]  TCPU_DEAD_RST   = 8'h00;
    localparam int TCPU_SYNC_STAGES = 2;
    localparam int TCPU_CNT_W       = 16;
    localparam int TCPU_NUM_UNITS   = 8;
    localparam int TCPU_DEAD_W      = 8;
    typedef enum logic [1:0] {
        TCPU_DB_OFF   = 2'b00,
        TCPU_DB_HIGH  = 2'b01,
        TCPU_DB_WAITL = 2'b11,
        TCPU_DB_LOW   = 2'b10
    } tcpu_db_t;
endpackage : tcpu_pkg

// file: hw/tcpu_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser per bit; first flop feeds only the second
module tcpu_sync
    import tcpu_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : tcpu_sync

// file: hw/tcpu_deadband.sv
`timescale 1ns/10ps
// splits one pwm line into true and complementary outputs with dead time
module tcpu_deadband
    import tcpu_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // control
    input  wire logic                   i_pwm,
    input  wire logic [TCPU_DEAD_W-1:0] i_dead,
    input  wire logic                   i_kill,
    input  wire logic                   i_kill_lvl,
    // outputs
    output logic                        o_line,
    output logic                        o_line_n
);
    tcpu_db_t                 st_q;
    logic [TCPU_DEAD_W-1:0]   cnt_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q     <= TCPU_DB_OFF;
            cnt_q    <= '0;
            o_line   <= 1'b0;
            o_line_n <= 1'b0;
        end else if (i_kill) begin
            // both switches forced to the safe level, timing restarts after release
            st_q     <= TCPU_DB_OFF;
            cnt_q    <= '0;
            o_line   <= i_kill_lvl;
            o_line_n <= i_kill_lvl;
        end else begin
            case (st_q)
                TCPU_DB_OFF: begin
                    // both off until dead time passes toward the wanted side
                    o_line   <= 1'b0;
                    o_line_n <= 1'b0;
                    if (cnt_q >= i_dead) begin
                        cnt_q <= '0;
                        st_q  <= i_pwm ? TCPU_DB_HIGH : TCPU_DB_LOW;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                TCPU_DB_HIGH: begin
                    o_line   <= i_pwm;
                    o_line_n <= 1'b0;
                    if (!i_pwm) begin
                        st_q <= TCPU_DB_WAITL;
                    end
                end
                TCPU_DB_WAITL: begin
                    o_line   <= 1'b0;
                    o_line_n <= 1'b0;
                    st_q     <= TCPU_DB_OFF;
                end
                TCPU_DB_LOW: begin
                    o_line   <= 1'b0;
                    o_line_n <= !i_pwm;
                    if (i_pwm) begin
                        st_q <= TCPU_DB_WAITL;
                    end
                end
                default: begin
                    st_q <= TCPU_DB_OFF;
                end
            endcase
        end
    end
endmodule : tcpu_deadband

// file: verif/tcpu_chk.sv
`timescale 1ns/10ps
module tcpu_chk
    import tcpu_pkg::*;
#(
    parameter int NUM_UNITS = 8
) (
    // clock and reset
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    // register port
    input wire logic [2:0]           i_unit,
    input wire logic [7:0]           i_addr,
    input wire logic [31:0]          i_wdata,
    input wire logic                 i_wr,
    input wire logic                 i_rd,
    input wire logic [31:0]          o_rdata,
    // pins
    input wire logic [NUM_UNITS-1:0] i_capture,
    input wire logic [NUM_UNITS-1:0] i_kill,
    input wire logic [NUM_UNITS-1:0] o_line,
    input wire logic [NUM_UNITS-1:0] o_line_n,
    // interrupt
    input wire logic                 o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // shadow of the kill mask bit of unit 0
    logic mk_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) mk_q <= 1'b0;
        else if (i_wr && i_unit == 3'h0 && i_addr == TCPU_OFS_MASK) mk_q <= i_wdata[TCPU_EV_KILL];
    end
    // kill level 0 is the only level the bench uses, so no pair may overlap
    AST_NO_OVERLAP: assert property ((o_line & o_line_n) == '0)
        else $error("both outputs of a pair high");
    AST_DEAD_T: assert property ($fell(o_line[0]) |=> !o_line_n[0])
        else $error("complement rose with no dead time");
    AST_DEAD_C: assert property ($fell(o_line_n[0]) |=> !o_line[0])
        else $error("true output rose with no dead time");
    AST_KILL_FORCE: assert property (i_kill[0] [*5] |-> o_line[0] == o_line_n[0])
        else $error("kill did not force the pair");
    AST_KILL_IRQ: assert property ((mk_q && i_kill[0]) [*5] |-> ##[0:2] o_irq)
        else $error("unmasked kill gave no interrupt");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    AST_UPPER_ZERO: assert property ($past(i_rd) && $past(i_addr) == TCPU_OFS_COUNT
        |-> o_rdata[31:16] == 16'h0) else $error("count wider than 16 bits");
    AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) > TCPU_OFS_MASK
        |-> o_rdata == 32'h0) else $error("unmapped index read nonzero");
    COV_KILL: cover property (i_kill[0] [*5]);
    COV_IRQ: cover property ($rose(o_irq));
    COV_CAPTURE: cover property ($rose(i_capture[2]));
endmodule : tcpu_chk

bind tcpu_top tcpu_chk #(.NUM_UNITS(NUM_UNITS)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_unit(i_unit), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_capture(i_capture), .i_kill(i_kill), .o_line(o_line), .o_line_n(o_line_n),
    .o_irq(o_irq)
);

// file: verif/tcpu_gate_model.sv
`timescale 1ns/10ps
// half-bridge gate drivers; overcurrent comes back as kill
module tcpu_gate_model (
    // clock
    input  wire logic       i_clk,
    // gate drive
    input  wire logic [7:0] i_line,
    input  wire logic [7:0] i_line_n,
    // overcurrent requests from the bench
    input  wire logic [7:0] i_fault,
    output logic      [7:0] o_kill,
    output int              o_shoot
);
    int shoot_q = 0;
    assign o_kill  = i_fault;
    assign o_shoot = shoot_q;
    // both switches on shorts the supply
    always @(posedge i_clk) begin
        if ((i_line & i_line_n) != 8'h00) shoot_q <= shoot_q + 1;
    end
endmodule : tcpu_gate_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
    import tcpu_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  unit = 3'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  cap = 8'h00;
    logic [7:0]  fault = 8'h00;
    logic [31:0] rdata, d;
    logic [7:0]  kill, line, line_n;
    logic        irq;
    int          shoot, gap, min_gap, hi, mx;
    int          failures = 0;
    int          check_count = 0;

    always #25 clk = ~clk;

    tcpu_top i_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_unit(unit), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_capture(cap), .i_kill(kill),
        .o_line(line), .o_line_n(line_n), .o_irq(irq)
    );
    tcpu_gate_model i_gate (
        .i_clk(clk), .i_line(line), .i_line_n(line_n), .i_fault(fault), .o_kill(kill),
        .o_shoot(shoot)
    );

    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [2:0] u, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        unit <= u;
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] u, input logic [7:0] a);
        @(posedge clk);
        unit <= u;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [2:0] u, input logic [7:0] a, input logic [31:0] e,
                          input string what);
        rd_reg(u, a);
        chk(what, e, d);
    endtask : rd_chk

    initial begin
        #4000000;
        failures++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(3'h7, TCPU_OFS_PERIOD, 32'hFFFF, "period rst");
        rd_chk(3'h0, TCPU_OFS_CMP, 32'h8000, "cmp rst");
        rd_chk(3'h0, TCPU_OFS_DEAD, 32'h0, "dead rst");
        rd_chk(3'h0, 8'h2A, 32'h0, "unmapped");
        wr_reg(3'h0, TCPU_OFS_PERIOD, 32'h9);
        wr_reg(3'h0, TCPU_OFS_CTRL, 32'h1);
        mx = 0;
        // stride of three cycles visits every count of the ten-cycle loop
        repeat (20) begin
            rd_reg(3'h0, TCPU_OFS_COUNT);
            if (d > mx) mx = d;
            @(posedge clk);
        end
        chk("count max", 32'h9, mx);
        rd_chk(3'h0, TCPU_OFS_STATUS, 32'h1, "match stat");
        wr_reg(3'h0, TCPU_OFS_CTRL, 32'h3);
        repeat (14) @(posedge clk);
        rd_chk(3'h0, TCPU_OFS_COUNT, 32'h9, "halt count");
        rd_chk(3'h0, TCPU_OFS_CTRL, 32'h2, "run cleared");
        wr_reg(3'h0, TCPU_OFS_PERIOD, 32'h13);
        // high time must outlast the dead band, or the pulse is swallowed
        wr_reg(3'h0, TCPU_OFS_CMP, 32'hA);
        wr_reg(3'h0, TCPU_OFS_DEAD, 32'h5);
        wr_reg(3'h0, TCPU_OFS_CTRL, 32'h1);
        wr_reg(3'h1, TCPU_OFS_CMP, 32'hFFFF);
        wr_reg(3'h1, TCPU_OFS_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        gap = -99;
        min_gap = 99;
        hi = 0;
        repeat (200) begin
            @(negedge clk);
            hi += line[0];
            if (line[0] | line_n[0]) begin
                if (gap > 0 && gap < min_gap) min_gap = gap;
                gap = 0;
            end else gap++;
        end
        chk("dead gap", 32'h1, {31'h0, min_gap >= 6});
        chk("duty", 32'h1, {31'h0, hi > 0 && hi <= 50});
        chk("u1 line", 32'h1, line[1]);
        wr_reg(3'h2, TCPU_OFS_COUNT, 32'h1234);
        cap <= 8'h04;
        repeat (5) @(posedge clk);
        rd_chk(3'h2, TCPU_OFS_CAPTURE, 32'h1234, "cap rise");
        rd_chk(3'h2, TCPU_OFS_STATUS, 32'h4, "cap stat");
        wr_reg(3'h2, TCPU_OFS_STATUS, 32'h4);
        rd_chk(3'h2, TCPU_OFS_STATUS, 32'h0, "stat w1c");
        wr_reg(3'h2, TCPU_OFS_CTRL, 32'h4);
        wr_reg(3'h2, TCPU_OFS_COUNT, 32'h55);
        cap <= 8'h00;
        repeat (5) @(posedge clk);
        wr_reg(3'h2, TCPU_OFS_CAPTURE, 32'hFFFF);
        rd_chk(3'h2, TCPU_OFS_CAPTURE, 32'h55, "cap fall");
        wr_reg(3'h0, TCPU_OFS_MASK, 32'h8);
        fault <= 8'h01;
        for (int k = 0; k < 8 && irq !== 1'b1; k++) @(negedge clk);
        chk("kill irq", 32'h1, irq);
        if (irq !== 1'b1) give_verdict();
        chk("kill line", 32'h0, {line[0], line_n[0]});
        chk("u1 kept", 32'h1, line[1]);
        rd_reg(3'h0, TCPU_OFS_STATUS);
        chk("kill stat", 32'h1, d[3]);
        chk("cmp stat", 32'h3, d[1:0]);
        @(posedge clk);
        fault <= 8'h00;
        repeat (4) @(posedge clk);
        wr_reg(3'h0, TCPU_OFS_STATUS, 32'h8);
        rd_reg(3'h0, TCPU_OFS_STATUS);
        chk("kill clr", 32'h0, d[3]);
        chk("irq low", 32'h0, irq);
        wr_reg(3'h0, TCPU_OFS_MASK, 32'h0);
        fault <= 8'h01;
        repeat (6) @(negedge clk);
        chk("masked irq", 32'h0, irq);
        chk("masked line", 32'h0, {line[0], line_n[0]});
        @(posedge clk);
        fault <= 8'h00;
        repeat (40) @(posedge clk);
        wr_reg(3'h1, TCPU_OFS_CTRL, 32'h11);
        repeat (8) @(negedge clk);
        chk("u1 invert", 32'h1, {line[1], line_n[1]});
        chk("shoot", 32'h0, shoot);
        give_verdict();
    end
endmodule : tb
